// ### design/evim_pkg.sv
package evim_pkg;

  // Interrupt and vector space
  localparam int NUM_IRQ  = 32;
  localparam int NUM_VEC  = 48;
  localparam int NUM_SYS  = 5;
  localparam int VEC_W    = 6;
  localparam int RANK_W   = 3;
  localparam int LVL_W    = 2;
  localparam logic [VEC_W-1:0] IRQ_VEC_BASE = 6'h10;

  // Vector table, fixed at address zero
  localparam logic [31:0] VTAB_BASE = 32'h0000_0000;
  localparam logic [VEC_W-1:0] VEC_SP_INIT = 6'h00;
  localparam logic [VEC_W-1:0] VEC_RESET   = 6'h01;

  // Register window and offsets from the system space base
  localparam logic [31:0] WIN_LO       = 32'hE000_E100;
  localparam logic [31:0] WIN_HI       = 32'hE000_ECFF;
  localparam logic [11:0] OFS_EN_SET   = 12'h100;
  localparam logic [11:0] OFS_EN_CLR   = 12'h180;
  localparam logic [11:0] OFS_PEND_SET = 12'h200;
  localparam logic [11:0] OFS_PEND_CLR = 12'h280;
  localparam logic [11:0] OFS_ACTIVE   = 12'h300;
  localparam logic [11:0] OFS_PRIO     = 12'h400;
  localparam logic [11:0] OFS_SYSPRI   = 12'hC00;
  localparam logic [11:0] OFS_STATUS   = 12'hC04;
  localparam int          NUM_PRIO_REG = 8;

  // Priority field: 8 bits per source, only the top two implemented
  localparam int               PRIO_FIELD_W = 8;
  localparam int               PRIO_LSB     = 6;
  localparam logic [LVL_W-1:0] PRIO_RESET   = 2'h0;

  // Interrupt bit positions of the dedicated sources
  localparam int IRQ_BROWNOUT  = 0;
  localparam int IRQ_WATCHDOG  = 1;
  localparam int IRQ_EXT_A     = 2;
  localparam int IRQ_EXT_B     = 3;
  localparam int IRQ_PORT_AB   = 4;
  localparam int IRQ_PORT_CDEF = 5;
  localparam int IRQ_PWM_LOW   = 6;
  localparam int IRQ_PWM_HIGH  = 7;
  localparam int IRQ_TIMER0    = 8;

  // Urgency ranks: smaller is more urgent
  localparam logic [RANK_W-1:0] RANK_NMI      = 3'h1;
  localparam logic [RANK_W-1:0] RANK_HARD     = 3'h2;
  localparam logic [RANK_W-1:0] RANK_CFG_BASE = 3'h3;
  localparam logic [RANK_W-1:0] RANK_NONE     = 3'h7;

  // System exceptions: nmi, hard fault, svcall, pendsv, systick
  localparam logic [NUM_SYS-1:0][VEC_W-1:0] SYS_VEC =
    {6'h0F, 6'h0E, 6'h0B, 6'h03, 6'h02};
  localparam logic [NUM_SYS-1:0] SYS_FIXED = 5'b0_0011;
  localparam logic [NUM_SYS-1:0][RANK_W-1:0] SYS_RANK =
    {3'h7, 3'h7, 3'h7, RANK_HARD, RANK_NMI};
  localparam logic [NUM_SYS-1:0][4:0] SYS_PRIO_POS =
    {5'h1E, 5'h16, 5'h06, 5'h00, 5'h00};

  // Pin synchroniser width: two dedicated pins, port A 16, port B 14
  localparam int PORT_A_W = 16;
  localparam int PORT_B_W = 14;
  localparam int PIN_W    = 2 + PORT_A_W + PORT_B_W;

  // Per-source control strobes
  typedef struct packed {
    logic             en_set;
    logic             en_clr;
    logic             pend_set;
    logic             pend_clr;
    logic             prio_we;
    logic [LVL_W-1:0] prio;
  } evim_cell_ctl_t;

  // Handler entry handed to the core
  typedef struct packed {
    logic [VEC_W-1:0] vector;
    logic [31:0]      addr;
  } evim_entry_t;

  typedef enum logic [2:0] {
    ST_SP_REQ,
    ST_SP_WAIT,
    ST_VEC_REQ,
    ST_VEC_WAIT,
    ST_IDLE
  } evim_state_t;

endpackage : evim_pkg

// ### design/evim_irq_cell.sv
`timescale 1ns/1ps
module evim_irq_cell
  import evim_pkg::*;
(
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Source and software controls
  input  wire logic             irq_in,
  input  wire evim_cell_ctl_t   ctl,
  // Activation and return
  input  wire logic             take,
  input  wire logic             retire,
  // State
  output logic                  enabled,
  output logic                  pending,
  output logic                  active,
  output logic [LVL_W-1:0]      level
);

  logic             en_reg;
  logic             pend_reg;
  logic             act_reg;
  logic [LVL_W-1:0] lvl_reg;

  // (R16) Pending ignores enable
  // Sets win over clears so that no request is lost; an active source is not re-pended by its input
  wire pend_next = (irq_in & ~act_reg & ~take) | ctl.pend_set
                 | (pend_reg & ~ctl.pend_clr & ~take);
  // (R17) Disable spares active
  wire en_next   = ctl.en_set | (en_reg & ~ctl.en_clr);
  // (R18) Clear-pending spares active
  wire act_next  = take | (act_reg & ~retire);

  // (R2) Level zero after reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_reg   <= 1'b0;
      pend_reg <= 1'b0;
      act_reg  <= 1'b0;
      lvl_reg  <= PRIO_RESET;
    end else begin
      en_reg   <= en_next;
      pend_reg <= pend_next;
      act_reg  <= act_next;
      if (ctl.prio_we) begin
        lvl_reg <= ctl.prio;
      end
    end
  end

  assign enabled = en_reg;
  assign pending = pend_reg;
  assign active  = act_reg;
  assign level   = lvl_reg;

endmodule : evim_irq_cell

// ### design/evim_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// (R1) Four software levels, zero most urgent
// (R2) All configurable levels reset to zero
// (R3) Reset, NMI, hard fault outrank level zero
// (R4) Thirty-two inputs map onto vectors 16-47
// (R5) Brown-out is bit 0, vector 16
// (R6) Port B pin 14 is bit 2
// (R7) Port B pin 15 is bit 3
// (R8) Port A/B pin changes merge onto bit 4
// (R9) PWM channels 0-3 merge onto bit 6
// (R10) PWM channels 4-7 merge into vector 23
// (R11) Handler address fetched by hardware
// (R12) Vector table base fixed at zero
// (R13) Word 0 loads initial stack pointer
// (R14) Handler word offset equals vector number
// (R15) Registers decoded in E100 to ECFF window
// (R16) Disabled request still becomes pending
// (R17) Disabling never cancels an active interrupt
// (R18) Clear-pending leaves active state alone
// (R19) Eight-bit priority fields, four per word
// (R20) Equal level: lower vector wins
// (R21) Preempt only when strictly more urgent
module evim_ctrl
  import evim_pkg::*;
(
  // Clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic [31:0]                hrdata,
  output logic                       hresp,
  // Peripheral requests, same clock
  input  wire logic                  brownout_irq,
  input  wire logic                  watchdog_irq,
  input  wire logic                  port_cdef_change_irq,
  input  wire logic [3:0]            pwm_low_ch_irq,
  input  wire logic [3:0]            pwm_high_ch_irq,
  input  wire logic                  timer_zero_irq,
  input  wire logic [NUM_IRQ-1:9]    periph_irq,
  // Pins, asynchronous
  input  wire logic                  ext_pin_irq_a,
  input  wire logic                  ext_pin_irq_b,
  input  wire logic [PORT_A_W-1:0]   port_a_pins,
  input  wire logic [PORT_B_W-1:0]   port_b_pins,
  // System exception requests
  input  wire logic                  nmi_req,
  input  wire logic                  hard_fault_req,
  input  wire logic                  svcall_req,
  input  wire logic                  pendsv_req,
  input  wire logic                  systick_req,
  // Core side
  input  wire logic                  exc_return,
  input  wire logic                  vtab_rvalid,
  input  wire logic [31:0]           vtab_rdata,
  output logic                       vtab_rd,
  output logic [31:0]                vtab_addr,
  output logic [31:0]                main_stack_ptr_init,
  output logic                       sp_load,
  output evim_entry_t                entry,
  output logic                       entry_valid
);

  // Bus state
  logic        hready_reg;
  logic [31:0] hrdata_reg;
  logic        hresp_reg;
  logic [31:0] a_addr_reg;
  logic        wr_pend_reg;
  logic        rd_pend_reg;

  // Pin synchronisers and change detect
  logic [PIN_W-1:0] pin_s1_reg;
  logic [PIN_W-1:0] pin_s2_reg;
  logic [PIN_W-1:0] pin_s3_reg;
  logic [PIN_W-1:0] pin_filt_reg;
  logic             port_ab_change_reg;

  // Sequencer
  evim_state_t      state_reg;
  evim_state_t      state_next;
  logic [VEC_W-1:0] vec_reg;
  logic             vtab_rd_reg;
  logic [31:0]      vtab_addr_reg;
  logic [31:0]      sp_init_reg;
  logic             sp_load_reg;
  evim_entry_t      entry_reg;
  logic             entry_valid_reg;

  // Address phase accept; reads take one wait state so data come from a flop
  wire bus_accept = hsel & htrans[1] & hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hready_reg  <= 1'b1;
      hresp_reg   <= 1'b0;
      a_addr_reg  <= 32'h0000_0000;
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
    end else begin
      hresp_reg   <= 1'b0;
      wr_pend_reg <= bus_accept & hwrite;
      rd_pend_reg <= bus_accept & ~hwrite;
      hready_reg  <= ~(bus_accept & ~hwrite);
      if (bus_accept) begin
        a_addr_reg <= haddr;
      end
    end
  end

  // (R15) Window decode
  wire        win_hit = (a_addr_reg >= WIN_LO) && (a_addr_reg <= WIN_HI);
  wire [11:0] ofs     = a_addr_reg[11:0];
  wire        wr_ok   = wr_pend_reg & win_hit;
  wire        wr_en_set   = wr_ok & (ofs == OFS_EN_SET);
  wire        wr_en_clr   = wr_ok & (ofs == OFS_EN_CLR);
  wire        wr_pend_set = wr_ok & (ofs == OFS_PEND_SET);
  wire        wr_pend_clr = wr_ok & (ofs == OFS_PEND_CLR);
  wire        wr_syspri   = wr_ok & (ofs == OFS_SYSPRI);
  wire        prio_hit    = (ofs[11:5] == OFS_PRIO[11:5]);
  wire        wr_prio     = wr_ok & prio_hit;
  wire [2:0]  prio_idx    = ofs[4:2];

  // Three-stage pin capture; a new level counts once stages two and three agree
  wire [PIN_W-1:0] pin_raw   = {port_b_pins, port_a_pins, ext_pin_irq_b, ext_pin_irq_a};
  wire [PIN_W-1:0] pin_agree = ~(pin_s2_reg ^ pin_s3_reg);
  wire [PIN_W-1:0] pin_next  = (pin_agree & pin_s3_reg) | (~pin_agree & pin_filt_reg);
  // (R8) Any port A/B edge
  wire port_ab_edge = |(pin_next[PIN_W-1:2] ^ pin_filt_reg[PIN_W-1:2]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_reg         <= '0;
      pin_s2_reg         <= '0;
      pin_s3_reg         <= '0;
      pin_filt_reg       <= '0;
      port_ab_change_reg <= 1'b0;
    end else begin
      pin_s1_reg         <= pin_raw;
      pin_s2_reg         <= pin_s1_reg;
      pin_s3_reg         <= pin_s2_reg;
      pin_filt_reg       <= pin_next;
      port_ab_change_reg <= port_ab_edge;
    end
  end

  // (R4) Source bit ordering onto the interrupt lines
  logic [NUM_IRQ-1:0] irq_src;
  // (R5) Brown-out on bit 0
  assign irq_src[IRQ_BROWNOUT]  = brownout_irq;
  assign irq_src[IRQ_WATCHDOG]  = watchdog_irq;
  // (R6) Dedicated pin A
  assign irq_src[IRQ_EXT_A]     = pin_filt_reg[0];
  // (R7) Dedicated pin B
  assign irq_src[IRQ_EXT_B]     = pin_filt_reg[1];
  assign irq_src[IRQ_PORT_AB]   = port_ab_change_reg;
  assign irq_src[IRQ_PORT_CDEF] = port_cdef_change_irq;
  // (R9) PWM low group merge
  assign irq_src[IRQ_PWM_LOW]   = |pwm_low_ch_irq;
  // (R10) PWM high group merge
  assign irq_src[IRQ_PWM_HIGH]  = |pwm_high_ch_irq;
  assign irq_src[IRQ_TIMER0]    = timer_zero_irq;
  assign irq_src[NUM_IRQ-1:9]   = periph_irq;

  // Per-source state collected from the cells
  logic [NUM_IRQ-1:0]            irq_en;
  logic [NUM_IRQ-1:0]            irq_pend;
  logic [NUM_IRQ-1:0]            irq_act;
  logic [NUM_IRQ-1:0][LVL_W-1:0] irq_lvl;
  logic [NUM_SYS-1:0]            sys_pend;
  logic [NUM_SYS-1:0]            sys_act;
  logic [NUM_SYS-1:0][LVL_W-1:0] sys_lvl;
  logic [NUM_SYS-1:0]            sys_req;
  logic [VEC_W-1:0]              cand_vec;
  logic [VEC_W-1:0]              cur_vec;
  logic [RANK_W-1:0]             cand_rank;
  logic [RANK_W-1:0]             cur_rank;
  logic                          take_go;

  assign sys_req = {systick_req, pendsv_req, svcall_req, hard_fault_req, nmi_req};
  wire cur_found = (cur_rank != RANK_NONE);

  // One cell per interrupt line
  for (genvar i = 0; i < NUM_IRQ; i++) begin : g_irq
    localparam int               BYTE = i % 4;
    localparam logic [VEC_W-1:0] VEC  = IRQ_VEC_BASE + VEC_W'(i);
    evim_cell_ctl_t ctl;
    assign ctl.en_set   = wr_en_set & hwdata[i];
    assign ctl.en_clr   = wr_en_clr & hwdata[i];
    assign ctl.pend_set = wr_pend_set & hwdata[i];
    assign ctl.pend_clr = wr_pend_clr & hwdata[i];
    // (R19) Field i%4 of word i/4
    assign ctl.prio_we  = wr_prio & (prio_idx == 3'(i / 4));
    assign ctl.prio     = hwdata[BYTE*PRIO_FIELD_W+PRIO_LSB +: LVL_W];
    evim_irq_cell u_cell (
      .hclk    (hclk),
      .hresetn (hresetn),
      .irq_in  (irq_src[i]),
      .ctl     (ctl),
      .take    (take_go & (cand_vec == VEC)),
      .retire  (exc_return & cur_found & (cur_vec == VEC)),
      .enabled (irq_en[i]),
      .pending (irq_pend[i]),
      .active  (irq_act[i]),
      .level   (irq_lvl[i])
    );
  end

  // System exceptions reuse the cell, always enabled, fixed ones never take a level
  for (genvar s = 0; s < NUM_SYS; s++) begin : g_sys
    evim_cell_ctl_t ctl;
    assign ctl.en_set   = 1'b1;
    assign ctl.en_clr   = 1'b0;
    assign ctl.pend_set = 1'b0;
    assign ctl.pend_clr = 1'b0;
    assign ctl.prio_we  = wr_syspri & ~SYS_FIXED[s];
    assign ctl.prio     = hwdata[SYS_PRIO_POS[s] +: LVL_W];
    evim_irq_cell u_cell (
      .hclk    (hclk),
      .hresetn (hresetn),
      .irq_in  (sys_req[s]),
      .ctl     (ctl),
      .take    (take_go & (cand_vec == SYS_VEC[s])),
      .retire  (exc_return & cur_found & (cur_vec == SYS_VEC[s])),
      .enabled (),
      .pending (sys_pend[s]),
      .active  (sys_act[s]),
      .level   (sys_lvl[s])
    );
  end

  // Flatten onto the vector space; unused vectors stay ineligible
  logic [NUM_VEC-1:0]             ready_all;
  logic [NUM_VEC-1:0]             act_all;
  logic [NUM_VEC-1:0][RANK_W-1:0] rank_v;

  always_comb begin
    ready_all = '0;
    act_all   = '0;
    rank_v    = {NUM_VEC{RANK_NONE}};
    for (int i = 0; i < NUM_IRQ; i++) begin
      ready_all[16+i] = irq_pend[i] & irq_en[i];
      act_all[16+i]   = irq_act[i];
      // (R1) Configurable ranks
      rank_v[16+i]    = RANK_CFG_BASE + RANK_W'(irq_lvl[i]);
    end
    for (int s = 0; s < NUM_SYS; s++) begin
      ready_all[SYS_VEC[s]] = sys_pend[s];
      act_all[SYS_VEC[s]]   = sys_act[s];
      // (R3) Fixed ranks above level zero
      rank_v[SYS_VEC[s]]    = SYS_FIXED[s] ? SYS_RANK[s]
                            : RANK_CFG_BASE + RANK_W'(sys_lvl[s]);
    end
  end

  // Most urgent member of a set; scanning downward with <= keeps the lowest vector
  function automatic logic [RANK_W+VEC_W-1:0] pick_best(
    input logic [NUM_VEC-1:0]             mask,
    input logic [NUM_VEC-1:0][RANK_W-1:0] rk
  );
    logic [RANK_W-1:0] best;
    logic [VEC_W-1:0]  bvec;
    best = RANK_NONE;
    bvec = '0;
    for (int v = NUM_VEC - 1; v >= 0; v--) begin
      // (R20) Lower vector on ties
      if (mask[v] && (rk[v] <= best)) begin
        best = rk[v];
        bvec = VEC_W'(v);
      end
    end
    return {best, bvec};
  endfunction : pick_best

  assign {cand_rank, cand_vec} = pick_best(ready_all, rank_v);
  assign {cur_rank, cur_vec}   = pick_best(act_all, rank_v);

  // (R21) Strictly more urgent
  // A return in the same cycle is served first so the running level is never stale
  assign take_go = (state_reg == ST_IDLE) & (cand_rank < cur_rank) & ~exc_return;

  // (R12) Table at zero
  // (R14) Word offset is the vector
  wire [31:0] vtab_word = VTAB_BASE + {24'h00_0000, vec_reg, 2'b00};

  // Fetch sequencer: stack pointer, reset entry, then one entry per activation
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_SP_REQ:   state_next = ST_SP_WAIT;
      ST_SP_WAIT:  state_next = vtab_rvalid ? ST_VEC_REQ : ST_SP_WAIT;
      ST_VEC_REQ:  state_next = ST_VEC_WAIT;
      ST_VEC_WAIT: state_next = vtab_rvalid ? ST_IDLE : ST_VEC_WAIT;
      ST_IDLE:     state_next = take_go ? ST_VEC_REQ : ST_IDLE;
      default:     state_next = ST_SP_REQ;
    endcase
  end

  // (R11) Hardware vector fetch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg       <= ST_SP_REQ;
      vec_reg         <= VEC_SP_INIT;
      vtab_rd_reg     <= 1'b0;
      vtab_addr_reg   <= VTAB_BASE;
      sp_init_reg     <= 32'h0000_0000;
      sp_load_reg     <= 1'b0;
      entry_reg       <= '0;
      entry_valid_reg <= 1'b0;
    end else begin
      state_reg       <= state_next;
      vtab_rd_reg     <= (state_reg == ST_SP_REQ) | (state_reg == ST_VEC_REQ);
      sp_load_reg     <= (state_reg == ST_SP_WAIT) & vtab_rvalid;
      entry_valid_reg <= (state_reg == ST_VEC_WAIT) & vtab_rvalid;
      if ((state_reg == ST_SP_REQ) || (state_reg == ST_VEC_REQ)) begin
        vtab_addr_reg <= vtab_word;
      end
      // (R13) Word 0 is the stack pointer
      if ((state_reg == ST_SP_WAIT) && vtab_rvalid) begin
        sp_init_reg <= vtab_rdata;
        vec_reg     <= VEC_RESET;
      end
      if (take_go) begin
        vec_reg <= cand_vec;
      end
      if ((state_reg == ST_VEC_WAIT) && vtab_rvalid) begin
        entry_reg <= '{vector: vec_reg, addr: vtab_rdata};
      end
    end
  end

  // Priority words read back; unimplemented low bits read zero
  logic [NUM_PRIO_REG-1:0][31:0] prio_rd;
  for (genvar k = 0; k < NUM_PRIO_REG; k++) begin : g_prd
    assign prio_rd[k] = {irq_lvl[4*k+3], 6'h00, irq_lvl[4*k+2], 6'h00,
                         irq_lvl[4*k+1], 6'h00, irq_lvl[4*k], 6'h00};
  end
  wire [31:0] syspri_rd = {sys_lvl[4], 6'h00, sys_lvl[3], 6'h00, 8'h00,
                           sys_lvl[2], 6'h00};
  wire [31:0] status_rd = {15'h0000, (cand_rank != RANK_NONE), 2'h0, cand_vec,
                           2'h0, cur_vec};

  // Read select; unmapped addresses read zero with OKAY
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (win_hit) begin
      case (ofs)
        OFS_EN_SET, OFS_EN_CLR:     rd_mux = irq_en;
        OFS_PEND_SET, OFS_PEND_CLR: rd_mux = irq_pend;
        OFS_ACTIVE:                 rd_mux = irq_act;
        OFS_SYSPRI:                 rd_mux = syspri_rd;
        OFS_STATUS:                 rd_mux = status_rd;
        default:                    rd_mux = prio_hit ? prio_rd[prio_idx] : 32'h0000_0000;
      endcase
    end
  end

  // Read data settle during the wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (rd_pend_reg) begin
      hrdata_reg <= rd_mux;
    end
  end

  assign hreadyout           = hready_reg;
  assign hrdata              = hrdata_reg;
  assign hresp               = hresp_reg;
  assign vtab_rd             = vtab_rd_reg;
  assign vtab_addr           = vtab_addr_reg;
  assign main_stack_ptr_init = sp_init_reg;
  assign sp_load             = sp_load_reg;
  assign entry               = entry_reg;
  assign entry_valid         = entry_valid_reg;

endmodule : evim_ctrl

// ### testbench/evim_ctrl_monitor.sv
`timescale 1ns/1ps
module evim_ctrl_monitor
  import evim_pkg::*;
(
  // Clock, reset and bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Vector fetch and core side
  input wire logic        vtab_rd,
  input wire logic [31:0] vtab_addr,
  input wire logic        vtab_rvalid,
  input wire logic [31:0] vtab_rdata,
  input wire logic [31:0] main_stack_ptr_init,
  input wire logic        sp_load,
  input wire evim_entry_t entry,
  input wire logic        entry_valid
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Read handshake: one wait cycle, then data
  sequence s_rd_acc;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence s_rd_ans;
    !hreadyout ##1 hreadyout;
  endsequence

  AST_READ_WAIT: assert property (s_rd_acc |=> s_rd_ans)
    else $error("read wait cycle wrong");
  AST_WRITE_NOWAIT: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
    else $error("write stalled");
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("error response");
  AST_VTAB_ADDR: assert property (vtab_rd |-> vtab_addr[1:0] == 2'b00 && vtab_addr < 32'd192)
    else $error("fetch outside table");
  AST_RD_PULSE: assert property (vtab_rd |=> !vtab_rd)
    else $error("fetch strobe too long");
  AST_SP_LOAD: assert property (sp_load |-> $past(vtab_rvalid)
      && vtab_addr == 32'h0000_0000 && main_stack_ptr_init == $past(vtab_rdata))
    else $error("stack value wrong");
  AST_VEC_AFTER_SP: assert property (sp_load |-> ##[1:3] (vtab_rd && vtab_addr == 32'h0000_0004))
    else $error("reset vector not fetched");
  AST_ENTRY_MATCH: assert property (entry_valid |-> entry.addr == $past(vtab_rdata)
      && vtab_addr == {24'h00_0000, entry.vector, 2'b00})
    else $error("entry not from its word");
  AST_ENTRY_VEC: assert property (entry_valid |-> entry.vector inside {6'h01, 6'h02, 6'h03,
      6'h0B, 6'h0E, 6'h0F} || (entry.vector >= 6'h10 && entry.vector <= 6'h2F))
    else $error("vector out of map");
  AST_ENTRY_PULSE: assert property (entry_valid |=> !entry_valid)
    else $error("entry strobe too long");
endmodule : evim_ctrl_monitor

bind evim_ctrl evim_ctrl_monitor u_mon (.*);

// ### testbench/evim_vtab_model.sv
`timescale 1ns/1ps
module evim_vtab_model (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Fetch request and answer delay
  input  wire logic        vtab_rd,
  input  wire logic [31:0] vtab_addr,
  input  wire logic [3:0]  lat,
  // Answer
  output logic             vtab_rvalid,
  output logic [31:0]      vtab_rdata
);
  logic [3:0]  cnt_reg;
  logic        busy_reg;
  logic [31:0] addr_reg;

  // hardware fetch answered; data toggles when idle so stale values never pass
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_reg    <= 1'b0;
      cnt_reg     <= 4'h0;
      addr_reg    <= 32'h0000_0000;
      vtab_rvalid <= 1'b0;
      vtab_rdata  <= 32'h0000_0000;
    end else begin
      vtab_rvalid <= 1'b0;
      vtab_rdata  <= ~vtab_rdata;
      if (vtab_rd) begin
        busy_reg <= 1'b1;
        cnt_reg  <= lat;
        addr_reg <= vtab_addr;
      end else if (busy_reg && cnt_reg == 4'h0) begin
        busy_reg    <= 1'b0;
        vtab_rvalid <= 1'b1;
        vtab_rdata  <= 32'hA5C3_0000 | addr_reg;
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end
endmodule : evim_vtab_model

// ### testbench/exception_vector_interrupt_map_tb.sv
`timescale 1ns/1ps
module exception_vector_interrupt_map_tb
  import evim_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, hready, exc_return;
  logic [31:0] haddr, hwdata, hrdata, vtab_addr, vtab_rdata, main_stack_ptr_init;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic brownout_irq, watchdog_irq, port_cdef_change_irq, timer_zero_irq, ext_pin_irq_a;
  logic ext_pin_irq_b, nmi_req, hard_fault_req, svcall_req, pendsv_req, systick_req;
  logic [3:0] pwm_low_ch_irq, pwm_high_ch_irq, lat;
  logic [NUM_IRQ-1:9] periph_irq;
  logic [PORT_A_W-1:0] port_a_pins;
  logic [PORT_B_W-1:0] port_b_pins;
  logic vtab_rvalid, vtab_rd, sp_load, entry_valid;
  evim_entry_t entry;
  int bad_count, check_count;
  logic [31:0] r;
  logic [5:0] v;

  assign hready = hreadyout;
  evim_ctrl u_dut (.*);
  evim_vtab_model u_mem (.*);

  // Free-running clock
  always #5 hclk = ~hclk;

  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Single AHB-Lite transfer, data taken when the data phase ends
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus

  task wait_entry(input logic [5:0] e);
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (entry_valid !== 1'b1 && i < 60);
    chk("vector", {26'h0, e}, (i < 60) ? {26'h0, entry.vector} : 32'hxxxx_xxxx);
    chk("handler", 32'hA5C3_0000 | {24'h0, e, 2'b00}, entry.addr);
  endtask : wait_entry

  task no_entry(input string n);
    logic seen;
    seen = 1'b0;
    repeat (20) @(posedge hclk) if (entry_valid !== 1'b0) seen = 1'b1;
    chk(n, 32'h0, {31'h0, seen});
  endtask : no_entry

  task ret;
    @(posedge hclk) exc_return <= 1'b1;
    @(posedge hclk) exc_return <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask : ret

  // Drive one source; port A/B pin sources stay high to avoid a second edge
  task src(input int i, input logic b);
    case (i)
      0: brownout_irq <= b;
      1: watchdog_irq <= b;
      2: ext_pin_irq_a <= b;
      3: ext_pin_irq_b <= b;
      4: port_a_pins[3] <= 1'b1;
      5: port_b_pins[13] <= 1'b1;
      6: pwm_low_ch_irq[3] <= b;
      7: pwm_high_ch_irq[0] <= b;
      8: timer_zero_irq <= b;
      9: port_cdef_change_irq <= b;
      default: periph_irq[31] <= b;
    endcase
  endtask : src

  task t_reset;
    wait_entry(6'h01);
    chk("stack", 32'hA5C3_0000, main_stack_ptr_init);
    $display("test reset done");
  endtask : t_reset

  task t_regs;
    bus(1'b0, 32'hE000_E400, 0); chk("prio0", 32'h0, r);
    bus(1'b0, 32'hE000_E41C, 0); chk("prio7", 32'h0, r);
    bus(1'b1, 32'hE000_E100, 32'hFFFF_FFFF);
    bus(1'b1, 32'hE000_E180, 32'h0000_FFFF);
    bus(1'b0, 32'hE000_E100, 0); chk("enable", 32'hFFFF_0000, r);
    bus(1'b0, 32'hE000_F100, 0); chk("outside", 32'h0, r);
    bus(1'b1, 32'hE000_E400, 32'hFFFF_40BF);
    bus(1'b0, 32'hE000_E400, 0); chk("prio", 32'hC0C0_4080, r);
    bus(1'b1, 32'hE000_E100, 32'hFFFF_FFFF);
    $display("test regs done");
  endtask : t_regs

  task t_map;
    logic [5:0] exp_vec [11];
    exp_vec = '{6'd16, 6'd17, 6'd18, 6'd19, 6'd20, 6'd20, 6'd22, 6'd23, 6'd24, 6'd21, 6'd47};
    for (int i = 0; i < 11; i++) begin
      @(posedge hclk) src(i, 1'b1);
      wait_entry(exp_vec[i]);
      @(posedge hclk) src(i, 1'b0);
      repeat (4) @(posedge hclk);
      ret;
    end
    $display("test map done");
  endtask : t_map

  task t_prio;
    bus(1'b1, 32'hE000_E180, 32'h0000_0003);
    @(posedge hclk) brownout_irq <= 1'b1;
    watchdog_irq <= 1'b1;
    lat <= 4'h5;
    no_entry("disabled");
    bus(1'b0, 32'hE000_E200, 0); chk("pending", 32'h3, r);
    bus(1'b1, 32'hE000_E100, 32'h0000_0003);
    wait_entry(6'd17);
    no_entry("no preempt");
    bus(1'b1, 32'hE000_E180, 32'h0000_0002);
    bus(1'b0, 32'hE000_E300, 0); chk("active", 32'h2, r);
    bus(1'b1, 32'hE000_E280, 32'h0000_0002);
    bus(1'b0, 32'hE000_E300, 0); chk("active", 32'h2, r);
    @(posedge hclk) watchdog_irq <= 1'b0;
    ret;
    wait_entry(6'd16);
    @(posedge hclk) nmi_req <= 1'b1;
    wait_entry(6'd2);
    @(posedge hclk) nmi_req <= 1'b0;
    brownout_irq <= 1'b0;
    ret;
    ret;
    @(posedge hclk) timer_zero_irq <= 1'b1;
    pwm_low_ch_irq <= 4'h1;
    wait_entry(6'd22);
    @(posedge hclk) timer_zero_irq <= 1'b0;
    pwm_low_ch_irq <= 4'h0;
    ret;
    wait_entry(6'd24);
    ret;
    $display("test prio done");
  endtask : t_prio

  task conclude;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude

  // Stimulus at time zero, then the tests in order
  initial begin
    {hclk, hresetn, hsel, hwrite, exc_return, brownout_irq, watchdog_irq} = '0;
    {port_cdef_change_irq, timer_zero_irq, ext_pin_irq_a, ext_pin_irq_b, nmi_req} = '0;
    {hard_fault_req, svcall_req, pendsv_req, systick_req} = '0;
    {haddr, hwdata, htrans, pwm_low_ch_irq, pwm_high_ch_irq, periph_irq} = '0;
    {port_a_pins, port_b_pins} = '0;
    hsize = 3'b010;
    lat = 4'h1;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_regs;
    t_map;
    t_prio;
    conclude;
  end

  // Hang guard, well past the expected run length
  initial begin
    #200us;
    bad_count++;
    conclude;
  end
endmodule : exception_vector_interrupt_map_tb
